// file: src/wdt_limits.sv
// decodes option fields into overflow, window and interval thresholds
`default_nettype none

module wdt_limits (
  input  wire logic [2:0]                 overflow_sel_in,
  input  wire logic [1:0]                 window_sel_in,
  input  wire logic                       standby_count_opt_in,
  output logic      [wdt_pkg::CNT_W-1:0]  ovf_last_out,
  output logic      [wdt_pkg::CNT_W-1:0]  close_end_out,
  output logic      [wdt_pkg::CNT_W-1:0]  irq_at_out
);

  logic [wdt_pkg::CNT_W-1:0] limit;

  // prohibited codes fall back to the longest legal time
  always_comb begin
    unique case (overflow_sel_in)
      3'b000:  limit = wdt_pkg::OVF_CNT_6;
      3'b001:  limit = wdt_pkg::OVF_CNT_7;
      3'b010:  limit = wdt_pkg::OVF_CNT_8;
      3'b011:  limit = wdt_pkg::OVF_CNT_9;
      default: limit = wdt_pkg::OVF_CNT_11;
    endcase
  end

  assign ovf_last_out = limit - 17'h00001;
  assign irq_at_out   = (limit >> 1) + (limit >> 2);

  // closed span ends at this count; zero means always open
  always_comb begin
    if (!standby_count_opt_in) begin
      close_end_out = '0;
    end else begin
      unique case (window_sel_in)
        2'b01:   close_end_out = limit >> 1;
        2'b10:   close_end_out = limit >> 2;
        default: close_end_out = '0;
      endcase
    end
  end

endmodule : wdt_limits

`default_nettype wire

// file: src/wdt_pkg.sv
// package: constants, option layout and register map of the windowed watchdog
// Notes on behaviour
// - count held in hidden 17-bit counter
// - 8-bit key write restarts the count
// - key register resets to 9A or 1A
// - any non-key write requests reset
// - single-bit access to key requests reset
// - key register reads back reset value only
// - enable option starts counter after reset
// - option byte fields configure the whole timer
// - later writes in closed window reset
// - first write clears regardless of window
// - overflow without key requests reset
// - clear lands within two slow clocks
// - key in last count still prevents reset
// - standby option decides counting in low power
// - wake from halt/stop restarts from zero when standby option is off
// - overflow codes give 2^6..2^9, 2^11 periods
// - counter advances on slow oscillator clock
// - window codes give 50, 75, 100 percent
// - standby option off forces full window
// - interval interrupt at 75 percent plus half
// - watchdog reset marks reset-cause bit 4
`default_nettype none

package wdt_pkg;

  // option byte, bit 7 down to bit 0
  typedef struct packed {
    logic       interval_irq_enable_opt;
    logic [1:0] window_sel;
    logic       count_enable_opt;
    logic [2:0] overflow_sel;
    logic       standby_count_opt;
  } wdt_opt_t;

  typedef struct packed {
    logic halt;
    logic stop;
    logic wake_assist_mode;
  } wdt_lowpwr_t;

  localparam int unsigned CNT_W        = 17;
  localparam logic [7:0]  KEY_VALUE    = 8'hAC;
  localparam logic [7:0]  RST_KEY_ON   = 8'h9A;
  localparam logic [7:0]  RST_KEY_OFF  = 8'h1A;
  localparam logic [7:0]  OPT_RESET    = 8'h00;
  localparam logic [3:0]  ADDR_KEY     = 4'h0;
  localparam logic [3:0]  ADDR_STATUS  = 4'h4;
  localparam logic [3:0]  BE_BYTE0     = 4'h1;
  localparam int unsigned RESET_CAUSE_REG_DOG_BIT = 4;

  // status register bits
  localparam int unsigned ST_RUN   = 0;
  localparam int unsigned ST_OPEN  = 1;
  localparam int unsigned ST_FIRST = 2;

  // overflow lengths in slow clock periods
  localparam logic [CNT_W-1:0] OVF_CNT_6  = 17'h00040;
  localparam logic [CNT_W-1:0] OVF_CNT_7  = 17'h00080;
  localparam logic [CNT_W-1:0] OVF_CNT_8  = 17'h00100;
  localparam logic [CNT_W-1:0] OVF_CNT_9  = 17'h00200;
  localparam logic [CNT_W-1:0] OVF_CNT_11 = 17'h00800;

endpackage : wdt_pkg

`default_nettype wire

// file: src/wdt_sync.sv
// two-flop synchroniser for pin-side levels
`default_nettype none

module wdt_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_sys_in,
  input  wire logic         srst_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule : wdt_sync

`default_nettype wire

// file: src/wdt_top.sv
// windowed watchdog: option capture, slow-clock counter, key register on avalon-mm
`default_nettype none

module wdt_top (
  input  wire logic        clk_sys_in,
  input  wire logic        srst_in,
  input  wire logic [7:0]  option_byte_in,
  input  wire logic        slow_osc_clk_in,
  input  wire logic        halt_in,
  input  wire logic        stop_in,
  input  wire logic        wake_assist_mode_in,
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  output logic             wdt_reset_req_out,
  output logic             interval_irq_out
);

  wdt_pkg::wdt_opt_t          opt;
  wdt_pkg::wdt_lowpwr_t       lp_raw;
  wdt_pkg::wdt_lowpwr_t       lp;
  logic [wdt_pkg::CNT_W-1:0]  cnt;
  logic [wdt_pkg::CNT_W-1:0]  ovf_last;
  logic [wdt_pkg::CNT_W-1:0]  close_end;
  logic [wdt_pkg::CNT_W-1:0]  irq_at;
  logic                       slow_q;
  logic                       slow_d;
  logic                       tick_rise;
  logic                       tick_fall;
  logic                       halt_stop_d;
  logic                       wake_clear;
  logic                       run;
  logic                       first_done;
  logic                       win_closed;
  logic                       acc_key_wr;
  logic                       key_good;
  logic                       bit_access;
  logic                       bad_value;
  logic                       win_error;
  logic                       key_clear;
  logic                       overflow;
  logic [7:0]                 key_read;
  logic [31:0]                next_readdata;

  assign lp_raw = '{halt: halt_in, stop: stop_in, wake_assist_mode: wake_assist_mode_in};

  wdt_sync #(.W(1)) u_slow_sync (
    .clk_sys_in (clk_sys_in),
    .srst_in    (srst_in),
    .async_in   (slow_osc_clk_in),
    .sync_out   (slow_q)
  );

  wdt_sync #(.W(3)) u_lp_sync (
    .clk_sys_in (clk_sys_in),
    .srst_in    (srst_in),
    .async_in   (lp_raw),
    .sync_out   (lp)
  );

  wdt_limits u_limits (
    .overflow_sel_in      (opt.overflow_sel),
    .window_sel_in        (opt.window_sel),
    .standby_count_opt_in (opt.standby_count_opt),
    .ovf_last_out         (ovf_last),
    .close_end_out        (close_end),
    .irq_at_out           (irq_at)
  );

  // option byte is sampled through reset and frozen after release
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      opt <= wdt_pkg::wdt_opt_t'(option_byte_in);
    end
  end

  // slow oscillator edges, seen through the synchroniser
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      slow_d      <= 1'b0;
      halt_stop_d <= 1'b0;
    end else begin
      slow_d      <= slow_q;
      halt_stop_d <= lp.halt | lp.stop;
    end
  end

  assign tick_rise  = slow_q & ~slow_d;
  assign tick_fall  = ~slow_q & slow_d;
  assign run        = opt.count_enable_opt &
                      (opt.standby_count_opt | ~(lp.halt | lp.stop | lp.wake_assist_mode));
  assign wake_clear = opt.count_enable_opt & ~opt.standby_count_opt &
                      halt_stop_d & ~(lp.halt | lp.stop);
  assign win_closed = cnt < close_end;

  // bus decode: a write takes effect on the edge where waitrequest is low
  assign acc_key_wr = avs_write_in & ~avs_waitrequest_out & (avs_address_in == wdt_pkg::ADDR_KEY);
  assign bit_access = acc_key_wr & (avs_byteenable_in != wdt_pkg::BE_BYTE0);
  assign bad_value  = acc_key_wr & (avs_writedata_in[7:0] != wdt_pkg::KEY_VALUE);
  // the window is only policed once counting is enabled
  assign win_error  = acc_key_wr & first_done & win_closed & opt.count_enable_opt;
  assign key_good   = acc_key_wr & ~bit_access & ~bad_value & ~win_error;
  assign key_clear  = key_good;
  // key on the final count beats the overflow
  assign overflow   = run & tick_rise & (cnt == ovf_last) & ~key_clear;

  // watchdog count, never visible on the bus
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      cnt <= '0;
    end else if (key_clear) begin
      cnt <= '0;
    end else if (wake_clear) begin
      cnt <= '0;
    end else if (run && tick_rise && cnt != ovf_last) begin
      cnt <= cnt + 17'h00001;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      first_done <= 1'b0;
    end else if (acc_key_wr) begin
      first_done <= 1'b1;
    end
  end

  // held until the reset controller resets the block; it records the cause bit
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      wdt_reset_req_out <= 1'b0;
    end else if (bit_access || bad_value || win_error || overflow) begin
      wdt_reset_req_out <= 1'b1;
    end
  end

  // half a slow period after reaching 75 percent, i.e. the next falling edge
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      interval_irq_out <= 1'b0;
    end else begin
      interval_irq_out <= opt.interval_irq_enable_opt & run & tick_fall & (cnt == irq_at);
    end
  end

  // one wait state per access keeps readdata registered
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      avs_waitrequest_out <= 1'b1;
    end else if ((avs_read_in || avs_write_in) && avs_waitrequest_out) begin
      avs_waitrequest_out <= 1'b0;
    end else begin
      avs_waitrequest_out <= 1'b1;
    end
  end

  assign key_read = opt.count_enable_opt ? wdt_pkg::RST_KEY_ON : wdt_pkg::RST_KEY_OFF;

  always_comb begin
    next_readdata = 32'h00000000;
    unique case (avs_address_in)
      wdt_pkg::ADDR_KEY: begin
        next_readdata[7:0] = key_read;
      end
      wdt_pkg::ADDR_STATUS: begin
        next_readdata[wdt_pkg::ST_RUN]   = run;
        next_readdata[wdt_pkg::ST_OPEN]  = ~win_closed;
        next_readdata[wdt_pkg::ST_FIRST] = first_done;
      end
      default: begin
        next_readdata = 32'h00000000;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      avs_readdata_out <= 32'h00000000;
    end else if (avs_read_in && avs_waitrequest_out) begin
      avs_readdata_out <= next_readdata;
    end
  end

  // checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);

  a_key_readback: assert property (
    avs_read_in && !avs_waitrequest_out && avs_address_in == wdt_pkg::ADDR_KEY
      |-> avs_readdata_out == {24'h000000, (opt.count_enable_opt ? 8'h9A : 8'h1A)})
    else $error("key register read did not return its reset value");

  a_bad_key_req: assert property (
    avs_write_in && !avs_waitrequest_out && avs_address_in == wdt_pkg::ADDR_KEY
      && avs_writedata_in[7:0] != 8'hAC |=> wdt_reset_req_out)
    else $error("wrong key value did not request reset");

  a_bit_access_req: assert property (
    avs_write_in && !avs_waitrequest_out && avs_address_in == wdt_pkg::ADDR_KEY
      && avs_byteenable_in != 4'h1 |=> wdt_reset_req_out)
    else $error("partial access to key register did not request reset");

  a_key_clears_cnt: assert property (
    key_good |=> cnt == '0 ##1 cnt <= 17'h00001)
    else $error("valid key did not restart the count");

  a_disabled_stays: assert property (
    !opt.count_enable_opt |-> cnt == '0 && !wdt_reset_req_out || $past(wdt_reset_req_out))
    else $error("disabled watchdog counted or overflowed");

  a_overflow_req: assert property (
    run && tick_rise && cnt == ovf_last && !key_good |=> wdt_reset_req_out)
    else $error("overflow did not request reset");

  a_last_count_key: assert property (
    run && tick_rise && cnt == ovf_last && key_good && !wdt_reset_req_out |=> !wdt_reset_req_out && cnt == '0)
    else $error("key on final count did not prevent reset");

  a_closed_window: assert property (
    acc_key_wr && first_done && cnt < close_end && opt.count_enable_opt |=> wdt_reset_req_out)
    else $error("write in closed window did not request reset");

  a_first_write_ok: assert property (
    acc_key_wr && !first_done && !bit_access && !bad_value && !wdt_reset_req_out && !overflow
      |=> !wdt_reset_req_out && cnt == '0)
    else $error("first key write was refused");

  a_standby_hold: assert property (
    !opt.standby_count_opt && (lp.halt || lp.stop || lp.wake_assist_mode) && !key_good && !wake_clear
      |=> $stable(cnt))
    else $error("counter moved in low power with standby counting off");

  a_interval_irq: assert property (
    interval_irq_out |-> $past(cnt) == irq_at && $past(opt.interval_irq_enable_opt) && !$past(slow_q))
    else $error("interval interrupt at the wrong count");

  a_full_window: assert property (
    !opt.standby_count_opt |-> !win_closed)
    else $error("window closed with standby counting off");

  c_key_clear:   cover property (key_good && cnt != '0);
  c_irq_fired:   cover property (interval_irq_out);
  c_win_reset:   cover property (win_error);
  c_ovf_reset:   cover property (overflow);

endmodule : wdt_top

`default_nettype wire

// file: test/testbench.sv
// self-checking testbench of the windowed watchdog
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct {
    logic [7:0] opt;
    logic [7:0] key;
    int         limit;
  } wdt_row_t;

  logic        clk_sys = 1'b0;
  logic        srst    = 1'b1;
  logic [7:0]  opt     = 8'h00;
  logic        slow    = 1'b0;
  logic        halt    = 1'b0;
  logic        stop    = 1'b0;
  logic        wake    = 1'b0;
  logic [3:0]  addr    = 4'h0;
  logic        rd      = 1'b0;
  logic        wr      = 1'b0;
  logic [31:0] wdata   = 32'h0;
  logic [3:0]  be      = 4'h0;
  logic [31:0] rdata;
  logic        waitreq;
  logic        rst_req;
  logic        irq;
  logic [1:0]  div      = 2'h0;
  int          tick_cnt = 0;
  int          fail_count = 0;
  int          num_checks = 0;
  int          ticks;
  logic [31:0] data;
  logic [31:0] key_w = {24'h0, wdt_pkg::KEY_VALUE};
  // limit 0 marks counting disabled
  wdt_row_t    rows [6] = '{'{8'h71, 8'h9A, 64}, '{8'h73, 8'h9A, 128}, '{8'h75, 8'h9A, 256},
                            '{8'h77, 8'h9A, 512}, '{8'h79, 8'h9A, 2048}, '{8'h61, 8'h1A, 0}};

  wdt_top wdt_top_i (
    .clk_sys_in          (clk_sys),
    .srst_in             (srst),
    .option_byte_in      (opt),
    .slow_osc_clk_in     (slow),
    .halt_in             (halt),
    .stop_in             (stop),
    .wake_assist_mode_in (wake),
    .avs_address_in      (addr),
    .avs_read_in         (rd),
    .avs_write_in        (wr),
    .avs_writedata_in    (wdata),
    .avs_byteenable_in   (be),
    .avs_readdata_out    (rdata),
    .avs_waitrequest_out (waitreq),
    .wdt_reset_req_out   (rst_req),
    .interval_irq_out    (irq)
  );

  always #25 clk_sys = ~clk_sys;

  // slow clock: 8 system clocks a period, well above the synchroniser minimum
  always @(posedge clk_sys) begin
    div <= div + 2'h1;
    if (div == 2'h3) begin
      slow <= ~slow;
      if (!slow) tick_cnt <= tick_cnt + 1;
    end
  end

  task automatic chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    begin
      num_checks++;
      if (got !== exp) begin
        fail_count++;
        $display("mismatch %s expected %0h seen %0h", name, exp, got);
      end
    end
  endtask : chk_val

  task automatic chk_range(input string name, input int lo, input int hi, input int got);
    begin
      num_checks++;
      if (got < lo || got > hi) begin
        fail_count++;
        $display("mismatch %s expected %0d..%0d seen %0d", name, lo, hi, got);
      end
    end
  endtask : chk_range

  task automatic results;
    begin
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask : results

  task automatic do_reset(input logic [7:0] o);
    begin
      srst <= 1'b1;
      opt  <= o;
      repeat (20) @(posedge clk_sys);
      @(negedge clk_sys);
      chk_val("reset outputs", 32'h2, {30'h0, waitreq, rst_req});
      @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
    end
  endtask : do_reset

  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
    int n;
    begin
      addr  <= a;
      wdata <= d;
      be    <= b;
      wr    <= w;
      rd    <= ~w;
      n = 0;
      // waitrequest and readdata are taken at the rising edge itself, before that edge updates them
      do begin
        @(posedge clk_sys);
        n++;
      end while (waitreq !== 1'b0 && n < 20);
      if (n >= 20) chk_val("bus answer", 32'h0, 32'h1);
      data = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk_sys);
    end
  endtask : bus

  // waits for reset request (sel 0) or interrupt (sel 1), counting slow ticks
  task automatic wait_ev(input logic sel, input int max, output int t);
    int start;
    int n;
    begin
      start = tick_cnt;
      n = 0;
      do begin
        @(negedge clk_sys);
        n++;
      end while (((sel ? irq : rst_req) !== 1'b1) && n < max * 8 + 16);
      t = tick_cnt - start;
      @(posedge clk_sys);
    end
  endtask : wait_ev

  initial begin
    // about twice the expected run length
    #(60000 * 50);
    fail_count++;
    $display("watchdog of the bench ran out");
    results();
  end

  initial begin
    foreach (rows[i]) begin
      do_reset(rows[i].opt);
      bus(1'b1, wdt_pkg::ADDR_KEY, key_w, wdt_pkg::BE_BYTE0);
      if (rows[i].limit > 0) begin
        wait_ev(1'b0, rows[i].limit + 8, ticks);
        chk_range("overflow ticks", rows[i].limit - 1, rows[i].limit + 1, ticks);
      end else begin
        wait_ev(1'b0, 100, ticks);
        chk_val("disabled counter", 32'h0, {31'h0, rst_req});
      end
      bus(1'b0, wdt_pkg::ADDR_KEY, 32'h0, 4'hF);
      chk_val("key read value", {24'h0, rows[i].key}, {24'h0, data[7:0]});
    end
    bus(1'b0, 4'h8, 32'h0, 4'hF);
    chk_val("unmapped read", 32'h0, data);
    // wrong key, then the right key on a partial lane
    for (int k = 0; k < 2; k++) begin
      do_reset(8'h71);
      bus(1'b1, wdt_pkg::ADDR_KEY, k ? key_w : 32'h55, k ? 4'h3 : wdt_pkg::BE_BYTE0);
      wait_ev(1'b0, 1, ticks);
      chk_val("bad key access", 32'h1, {31'h0, rst_req});
    end
    // 50% window: first write anywhere, second in closed part fails
    do_reset(8'h31);
    bus(1'b1, wdt_pkg::ADDR_KEY, key_w, wdt_pkg::BE_BYTE0);
    wait_ev(1'b0, 5, ticks);
    chk_val("early first write", 32'h0, {31'h0, rst_req});
    bus(1'b0, wdt_pkg::ADDR_STATUS, 32'h0, 4'hF);
    chk_val("status word", 32'h5, data);
    bus(1'b1, wdt_pkg::ADDR_KEY, key_w, wdt_pkg::BE_BYTE0);
    wait_ev(1'b0, 1, ticks);
    chk_val("closed window write", 32'h1, {31'h0, rst_req});
    // open-window writes keep it alive past one overflow span
    do_reset(8'h31);
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, wdt_pkg::ADDR_KEY, key_w, wdt_pkg::BE_BYTE0);
      wait_ev(1'b0, 40, ticks);
    end
    chk_val("open window keepalive", 32'h0, {31'h0, rst_req});
    do_reset(8'hF1);
    bus(1'b1, wdt_pkg::ADDR_KEY, key_w, wdt_pkg::BE_BYTE0);
    wait_ev(1'b1, 60, ticks);
    chk_range("interval ticks", 47, 49, ticks);
    wait_ev(1'b0, 24, ticks);
    chk_range("overflow after irq", 14, 17, ticks);
    // standby off: full window, pauses; halt and stop restart from zero
    do_reset(8'h30);
    bus(1'b1, wdt_pkg::ADDR_KEY, key_w, wdt_pkg::BE_BYTE0);
    for (int m = 0; m < 3; m++) begin
      bus(1'b1, wdt_pkg::ADDR_KEY, key_w, wdt_pkg::BE_BYTE0);
      wait_ev(1'b0, 40, ticks);
      chk_val("full window write", 32'h0, {31'h0, rst_req});
      {wake, stop, halt} <= 3'b001 << m;
      wait_ev(1'b0, 100, ticks);
      chk_val("paused counter", 32'h0, {31'h0, rst_req});
      {wake, stop, halt} <= 3'b000; // full overflow span left after halt or stop, only the unused rest after wake assist mode
      wait_ev(1'b0, 72, ticks);
      chk_range("ticks after wake", m == 2 ? 22 : 62, m == 2 ? 27 : 67, ticks);
      do_reset(8'h30);
    end
    results();
  end

endmodule : testbench

`default_nettype wire
